// ### design/mps_cfg.svh
// timing constants and defaults for the module power sequencer
`ifndef MPS_CFG_SVH
`define MPS_CFG_SVH
`define MPS_CLK_HZ 20000000
`define MPS_TICK_US 1000
`define MPS_RESET_HOLD_MS 1000
`define MPS_BOOT_MS 50000
`define MPS_FINAL_MS 2000
`define MPS_OFF_REBOOT_MS 1000
`endif

// ### design/mps_pkg.sv
// types shared by the module power sequencer
`default_nettype none
package mps_pkg;
    typedef enum logic [2:0] {
        MPS_OFF,
        MPS_BOOT,
        MPS_ACTIVE,
        MPS_FINAL,
        MPS_DOWN,
        MPS_RESET
    } mps_state_t;
endpackage
`default_nettype wire

// ### design/mps_tick_if.sv
// tick carrier between the divider and the sequencer
`default_nettype none
interface mps_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface
`default_nettype wire

// ### design/mps_tick_div.sv
// divider making a one-cycle millisecond enable pulse
`include "mps_cfg.svh"
`default_nettype none
module mps_tick_div #(
    parameter int unsigned DIV = (`MPS_CLK_HZ / 1000000) * `MPS_TICK_US
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    mps_tick_if.src tick_if
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } mps_div_t;
    mps_div_t s_reg;
    mps_div_t s_next;
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.cnt >= DIV - 1) begin
            s_next.cnt = 32'h0;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + 32'h1;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign tick_if.tick = s_reg.tick;
endmodule
`default_nettype wire

// ### design/mps_sequencer.sv
// module power sequencer: power on, graceful and fast shutdown, hardware reset
`include "mps_cfg.svh"
`default_nettype none
module mps_sequencer
    import mps_pkg::*;
#(
    parameter int unsigned RESET_HOLD_MS = `MPS_RESET_HOLD_MS,
    parameter int unsigned BOOT_MS = `MPS_BOOT_MS,
    parameter int unsigned FINAL_MS = `MPS_FINAL_MS,
    parameter int unsigned OFF_REBOOT_MS = `MPS_OFF_REBOOT_MS,
    parameter int unsigned TICK_DIV = (`MPS_CLK_HZ / 1000000) * `MPS_TICK_US
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic main_supply_in,
    input wire logic card_power_request_in,
    input wire logic restart_request_low_in,
    input wire logic fast_shutdown_trigger_in,
    input wire logic fast_shutdown_enable_in,
    input wire logic shutdown_indicator_enable_in,
    output logic ref_rail_1v8_out,
    output logic boot_done_out,
    output logic active_out
);
    typedef struct packed {
        mps_state_t st;
        logic [1:0] pwr_sync;
        logic [2:0] rst_sync;
        logic [2:0] fst_sync;
        logic [1:0] sup_sync;
        logic [1:0] fen_sync;
        logic [1:0] ind_sync;
        logic [31:0] tmr;
        logic [31:0] rst_tmr;
        logic rst_armed;
        logic fast_latch;
        logic ref_rail;
        logic boot_done;
        logic active;
    } mps_seq_t;
    mps_seq_t s_reg;
    mps_seq_t s_next;
    mps_tick_if tick_bus ();
    mps_tick_div #(.DIV(TICK_DIV)) u_div (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .tick_if(tick_bus)
    );
    logic pwr;
    logic rst_low;
    logic fst_fall;
    logic sup;
    logic fen;
    logic ind;
    logic tick;
    always_comb begin
        pwr = s_reg.pwr_sync[1];
        rst_low = ~s_reg.rst_sync[1];
        fst_fall = s_reg.fst_sync[2] & ~s_reg.fst_sync[1];
        sup = s_reg.sup_sync[1];
        fen = s_reg.fen_sync[1];
        ind = s_reg.ind_sync[1];
        tick = tick_bus.tick;
        s_next = s_reg;
        s_next.pwr_sync = {s_reg.pwr_sync[0], card_power_request_in};
        s_next.rst_sync = {s_reg.rst_sync[1:0], restart_request_low_in};
        s_next.fst_sync = {s_reg.fst_sync[1:0], fast_shutdown_trigger_in};
        s_next.sup_sync = {s_reg.sup_sync[0], main_supply_in};
        s_next.fen_sync = {s_reg.fen_sync[0], fast_shutdown_enable_in};
        s_next.ind_sync = {s_reg.ind_sync[0], shutdown_indicator_enable_in};
        if (tick) begin
            s_next.tmr = s_reg.tmr + 32'h1;
        end
        // restart hold timer runs in every state; reset fires on release
        if (rst_low) begin
            // one tick past the limit: the tick phase is free, so the hold is surely long enough
            if (tick && s_reg.rst_tmr <= RESET_HOLD_MS) begin
                s_next.rst_tmr = s_reg.rst_tmr + 32'h1;
            end
            if (s_reg.rst_tmr > RESET_HOLD_MS) begin
                s_next.rst_armed = 1'b1;
            end
        end else begin
            s_next.rst_tmr = 32'h0;
            s_next.rst_armed = 1'b0;
        end
        case (s_reg.st)
            MPS_OFF: begin
                s_next.ref_rail = 1'b0;
                s_next.boot_done = 1'b0;
                s_next.active = 1'b0;
                // a latched fast shutdown with indicator holds off until supply drops or a hardware reset clears the latch
                if (!sup) begin
                    s_next.fast_latch = 1'b0;
                end
                if (sup && !s_reg.fast_latch && (pwr || rst_low)) begin
                    s_next.st = MPS_BOOT;
                    s_next.tmr = 32'h0;
                end
            end
            MPS_BOOT: begin
                s_next.ref_rail = 1'b1;
                // one extra tick so a late tick phase never shortens the boot
                if (s_reg.tmr > BOOT_MS) begin
                    s_next.st = MPS_ACTIVE;
                    s_next.active = 1'b1;
                    s_next.boot_done = ind;
                end
                // power request dropped mid-boot is ignored until boot ends
            end
            MPS_ACTIVE: begin
                s_next.boot_done = ind;
                if (!pwr) begin
                    s_next.st = MPS_FINAL;
                    s_next.tmr = 32'h0;
                    s_next.active = 1'b0;
                end else if (fen && fst_fall) begin
                    s_next.st = MPS_FINAL;
                    s_next.tmr = 32'h0;
                    s_next.active = 1'b0;
                    s_next.fast_latch = ind;
                end
            end
            MPS_FINAL: begin
                if (s_reg.tmr >= FINAL_MS) begin
                    s_next.st = MPS_DOWN;
                    s_next.tmr = 32'h0;
                    s_next.ref_rail = 1'b0;
                    s_next.boot_done = 1'b0;
                end
            end
            MPS_DOWN: begin
                // supply left on with power request high reboots after OFF_REBOOT_MS unless a fast shutdown latched the indicator
                if (!sup || s_reg.fast_latch) begin
                    s_next.st = MPS_OFF;
                end else if (s_reg.tmr >= OFF_REBOOT_MS && pwr) begin
                    s_next.st = MPS_BOOT;
                    s_next.tmr = 32'h0;
                end else if (!pwr && !rst_low) begin
                    s_next.st = MPS_OFF;
                end
            end
            MPS_RESET: begin
                s_next.ref_rail = 1'b0;
                s_next.boot_done = 1'b0;
                s_next.active = 1'b0;
                s_next.fast_latch = 1'b0;
                s_next.st = MPS_OFF;
                if (sup) begin
                    s_next.st = MPS_BOOT;
                    s_next.tmr = 32'h0;
                end
            end
            default: begin
                s_next.st = MPS_OFF;
            end
        endcase
        // reset wins over every state once the long low is released, and loses only to a supply drop
        if (s_reg.rst_armed && !rst_low) begin
            s_next.st = MPS_RESET;
            s_next.ref_rail = 1'b0;
            s_next.boot_done = 1'b0;
            s_next.active = 1'b0;
        end
        if (!sup) begin
            s_next.st = MPS_OFF;
            s_next.ref_rail = 1'b0;
            s_next.boot_done = 1'b0;
            s_next.active = 1'b0;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            s_reg <= '0;
            s_reg.st <= MPS_OFF;
            s_reg.rst_sync <= 3'h7;
            s_reg.fst_sync <= 3'h7;
        end else begin
            s_reg <= s_next;
        end
    end
    assign ref_rail_1v8_out = s_reg.ref_rail;
    assign boot_done_out = s_reg.boot_done;
    assign active_out = s_reg.active;
endmodule
`default_nettype wire

// ### verification/mps_seq_sva.sv
// port checker for the module power sequencer
`default_nettype none
module mps_seq_sva #(
    parameter int unsigned BOOT_MS = 20,
    parameter int unsigned FINAL_MS = 4,
    parameter int unsigned TICK_DIV = 4
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic main_supply_in,
    input wire logic card_power_request_in,
    input wire logic restart_request_low_in,
    input wire logic fast_shutdown_trigger_in,
    input wire logic fast_shutdown_enable_in,
    input wire logic shutdown_indicator_enable_in,
    input wire logic ref_rail_1v8_out,
    input wire logic boot_done_out,
    input wire logic active_out
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FIN_MAX = (FINAL_MS + 2) * TICK_DIV + 8;
    // cycles the rail has been up, held against the full boot time
    int unsigned up_reg;
    always_ff @(posedge mclk_in) begin
        up_reg <= (srst_in || !ref_rail_1v8_out) ? 0 : up_reg + 1;
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    sequence s_steady;
        (main_supply_in && card_power_request_in && restart_request_low_in
            && !fast_shutdown_enable_in) [*6];
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0) srst_in |=>
        !(ref_rail_1v8_out || boot_done_out || active_out)) else $error("outputs not idle");
    a_active_rail: assert property (active_out |-> ref_rail_1v8_out)
        else $error("active without rail");
    a_boot_time: assert property ($rose(active_out) |->
        up_reg >= BOOT_MS * TICK_DIV) else $error("boot too short");
    a_done_cfg: assert property ($rose(boot_done_out) |->
        shutdown_indicator_enable_in) else $error("indicator while disabled");
    a_done_boot: assert property ($rose(active_out) && shutdown_indicator_enable_in |->
        ##[0:1] boot_done_out) else $error("boot done missing");
    a_graceful_go: assert property (active_out && !card_power_request_in |->
        ##[1:6] !active_out) else $error("request low ignored");
    a_rail_off: assert property ($fell(active_out) && !card_power_request_in |->
        ##[1:FIN_MAX] !ref_rail_1v8_out) else $error("rail stays up");
    a_fast_off: assert property (s_steady ##0 active_out |=> active_out)
        else $error("left active while fast shutdown off");
endmodule
bind mps_sequencer mps_seq_sva #(.BOOT_MS(BOOT_MS), .FINAL_MS(FINAL_MS), .TICK_DIV(TICK_DIV))
    i_mps_seq_sva (.mclk_in(mclk_in), .srst_in(srst_in), .main_supply_in(main_supply_in),
    .card_power_request_in(card_power_request_in),
    .restart_request_low_in(restart_request_low_in),
    .fast_shutdown_trigger_in(fast_shutdown_trigger_in),
    .fast_shutdown_enable_in(fast_shutdown_enable_in),
    .shutdown_indicator_enable_in(shutdown_indicator_enable_in),
    .ref_rail_1v8_out(ref_rail_1v8_out), .boot_done_out(boot_done_out),
    .active_out(active_out));
`default_nettype wire

// ### verification/mps_host_model.sv
// host side model driving the supply, power request and restart pins
`default_nettype none
module mps_host_model (
    input wire logic supply_on_in,
    input wire logic pwr_on_in,
    input wire logic pull_in,
    output logic main_supply_out,
    output logic card_power_request_out,
    output logic restart_request_low_out
);
    timeunit 1ns;
    timeprecision 1ns;
    assign main_supply_out = supply_on_in;  // request may follow supply at once
    assign card_power_request_out = pwr_on_in;  // held for the whole on time
    // open collector stand-in: pulls low on pull_in, drives the pin high itself otherwise
    assign restart_request_low_out = pull_in ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ### verification/mps_sequencer_tb.sv
// bench for the module power sequencer
`default_nettype none
module mps_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TD = 4;
    localparam int BT = 20;
    localparam int FN = 4;
    logic mclk_in = 0;
    logic srst_in = 1;
    logic sup = 0, pwr = 0, pull = 0, trig = 0, fse = 0, sie = 0;
    wire logic sup_w, req_w, rst_w, rail, bdone, act;
    wire logic [2:0] outs = {act, bdone, rail};
    int n_fail = 0;
    int compares = 0;
    int t;
    initial begin
        forever #25 mclk_in = ~mclk_in;
    end
    mps_host_model i_mps_host_model (.supply_on_in(sup), .pwr_on_in(pwr), .pull_in(pull),
        .main_supply_out(sup_w), .card_power_request_out(req_w), .restart_request_low_out(rst_w));
    mps_sequencer #(.RESET_HOLD_MS(5), .BOOT_MS(BT), .FINAL_MS(FN), .OFF_REBOOT_MS(3),
        .TICK_DIV(TD)) i_mps_sequencer (.mclk_in(mclk_in), .srst_in(srst_in),
        .main_supply_in(sup_w), .card_power_request_in(req_w), .restart_request_low_in(rst_w),
        .fast_shutdown_trigger_in(trig), .fast_shutdown_enable_in(fse),
        .shutdown_indicator_enable_in(sie), .ref_rail_1v8_out(rail), .boot_done_out(bdone),
        .active_out(act));
    task automatic chk(input logic seen, input logic exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t saw %b want %b", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d fails %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // waits at most n cycles for outs[s] (rail, boot done, active) to reach v
    task automatic wfor(input int s, input logic v, input int n);
        t = 0;
        while (outs[s] !== v) begin
            if (t == n) begin
                chk(1'b0, 1'b1);
                report_and_stop();
            end
            @(negedge mclk_in);
            t++;
        end
    endtask
    task automatic boot(input logic ind);
        sie = ind;
        sup = 1;
        pwr = 1;
        wfor(2, 1, BT * TD + 20);
        chk(t >= BT * TD, 1);
        @(negedge mclk_in);
        chk(bdone, ind);
        chk(rail, 1);
    endtask
    // supply only goes once the rail is down
    task automatic off();
        pwr = 0;
        wfor(0, 0, (BT + FN + 3) * TD + 40);
        sup = 0;
        repeat (4) @(negedge mclk_in);
    endtask
    task automatic t_graceful();
        boot(0);
        pwr = 0;
        wfor(2, 0, 10);
        chk(rail, 1);
        wfor(0, 0, FN * TD + 10);
        chk(t >= (FN - 1) * TD - 4, 1);
        chk(bdone, 0);
        repeat (4 * TD + 10) @(negedge mclk_in);
        chk(rail, 0);
        off();
        $display("graceful done");
    endtask
    task automatic t_early();
        sup = 1;
        pwr = 1;
        repeat (10) @(negedge mclk_in);
        pwr = 0;
        wfor(0, 0, (BT + FN) * TD + 20);
        chk(t >= (BT - 1) * TD, 1);
        off();
        $display("early drop done");
    endtask
    task automatic t_fast(input logic en, input logic ind);
        boot(ind);
        fse = en;
        trig = 1;
        repeat (2) @(negedge mclk_in);
        trig = 0;  // stays low so no high level meets a module going off
        repeat (8) @(negedge mclk_in);
        chk(act, !en);
        if (en) begin
            wfor(0, 0, FN * TD + 10);
            chk(bdone, 0);
            repeat (3 * TD + 12) @(negedge mclk_in);
            chk(rail, !ind);
        end
        fse = 0;
        off();
        $display("fast shutdown done");
    endtask
    task automatic t_restart();
        boot(0);
        pull = 1;
        repeat (6 * TD + 8) @(negedge mclk_in);
        pull = 0;
        wfor(2, 0, 10);
        wfor(2, 1, BT * TD + 20);
        off();
        sup = 1;
        repeat (4) @(negedge mclk_in);
        pull = 1;
        repeat (4) @(negedge mclk_in);
        pull = 0;
        wfor(0, 1, 10);
        off();
        $display("restart done");
    endtask
    initial begin
        repeat (2) @(negedge mclk_in);
        srst_in = 0;
        repeat (2) @(negedge mclk_in);
        chk(rail | bdone | act, 0);
        t_graceful();
        t_early();
        t_fast(0, 0);
        t_fast(1, 0);
        t_fast(1, 1);
        t_restart();
        report_and_stop();
    end
endmodule
`default_nettype wire
